/* rtl/lcr_flag.sv */
// lcr_flag: sticky flag, hardware set wins over software clear
// assumes: set and clear are one-cycle pulses on clk_sys_i
`timescale 1ns/1ps
module lcr_flag (
	// clock and reset
	input  wire logic clk_sys_i,
	input  wire logic rst_i,
	// control
	input  wire logic set_i,
	input  wire logic clr_i,
	output logic      flag_o
);
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			flag_o <= 1'b0;
		end else if (set_i) begin
			flag_o <= 1'b1;
		end else if (clr_i) begin
			flag_o <= 1'b0;
		end
	end
endmodule

/* rtl/lcr_pkg.sv */
// lcr_pkg: register map, field positions and reset values of the control register slave
// assumes: 32-bit register port, byte addresses, one word per register
package lcr_pkg;
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 32;
	typedef logic [ADDR_W-1:0] lcr_addr_t;
	typedef logic [DATA_W-1:0] lcr_data_t;
	// block-level control and interrupt window, 0x000 to 0x00c
	localparam lcr_addr_t OFS_CTRL     = 12'h000;
	localparam lcr_addr_t OFS_GIE      = 12'h004;
	localparam lcr_addr_t OFS_IER      = 12'h008;
	localparam lcr_addr_t OFS_ISR      = 12'h00c;
	localparam lcr_addr_t CTRL_TOP     = 12'h00c;
	// argument registers
	localparam lcr_addr_t OFS_ARG_A    = 12'h010;
	localparam lcr_addr_t OFS_ARG_B    = 12'h018;
	localparam lcr_addr_t OFS_ARG_BVLD = 12'h01c;
	localparam lcr_addr_t OFS_ARG_BACK = 12'h020;
	localparam lcr_addr_t OFS_ARG_C    = 12'h400;
	// control word fields
	localparam int unsigned CTRL_START = 0;
	localparam int unsigned CTRL_DONE  = 1;
	localparam int unsigned CTRL_IDLE  = 2;
	localparam int unsigned CTRL_READY = 3;
	// interrupt fields: completion and input accept
	localparam int unsigned IRQ_W      = 2;
	localparam int unsigned IRQ_DONE   = 0;
	localparam int unsigned IRQ_READY  = 1;
	localparam lcr_data_t   RST_WORD   = 32'h0000_0000;
	typedef enum logic [1:0] {
		LCR_IDLE = 2'b00,
		LCR_WAIT = 2'b01,
		LCR_RUN  = 2'b11
	} lcr_state_t;
endpackage

/* rtl/lcr_slave.sv */
// lcr_slave: register slave for block control, arguments and interrupt
// assumes: one clock, register port with read data one cycle after the read strobe,
// the kernel logic sits outside and handshakes through the core port group
// Contract
// - grouped arguments share one register port
// - ungrouped arguments land in one default port
// - handshake argument gets data, ack, valid
// - consuming argument clears its valid register
// - invalid data stalls until valid set
// - argument registers clear only on reset
// - explicit offset places argument there
// - 0x000 to 0x00c kept for control
// - function return gives programmable interrupt
// - interrupt on completion and input accept
// - arrays only as memory style ports
// - constant arguments never mapped here
// - separate port reset is active low; this slave has no separate port reset, only the shared active-high rst_i
`timescale 1ns/1ps
module lcr_slave
	import lcr_pkg::*;
#(
	parameter int unsigned ARG_W = 32
) (
	// clock and reset
	input  wire logic              clk_sys_i,
	input  wire logic              rst_i,
	// register port
	input  wire lcr_pkg::lcr_addr_t reg_addr_i,
	input  wire lcr_pkg::lcr_data_t reg_wdata_i,
	input  wire logic              reg_wr_i,
	input  wire logic              reg_rd_i,
	output lcr_pkg::lcr_data_t     reg_rdata_o,
	output logic                   reg_err_o,
	// kernel core handshake, same clock
	output logic                   core_start_o,
	input  wire logic              core_done_i,
	input  wire logic              core_ready_i,
	input  wire logic              core_idle_i,
	input  wire logic              core_b_rd_i,
	output logic [ARG_W-1:0]       arg_a_o,
	output logic [ARG_W-1:0]       arg_b_o,
	output logic                   arg_b_vld_o,
	input  wire logic [ARG_W-1:0]  arg_c_i,
	input  wire logic              arg_c_vld_i,
	// pin-level stall for the kernel, asynchronous source
	input  wire logic              ext_hold_i,
	output logic                   stall_o,
	// interrupt
	output logic                   irq_o
);
	localparam lcr_data_t ZERO = RST_WORD;

	lcr_state_t state_q;
	logic       start_q;
	logic       done_seen_q;
	logic       gie_q;
	logic [IRQ_W-1:0] ier_q;
	logic [IRQ_W-1:0] isr;
	logic [IRQ_W-1:0] isr_clr;
	logic [ARG_W-1:0] a_q;
	logic [ARG_W-1:0] b_q;
	logic       b_vld_q;
	logic       b_ack_q;
	logic [ARG_W-1:0] c_q;
	logic       hold_s;
	logic       wr_ctrl;
	logic       wr_gie;
	logic       wr_ier;
	logic       wr_isr;
	logic       wr_a;
	logic       wr_b;
	logic       wr_bvld;
	logic       hit;
	logic       b_vld_nx;
	lcr_data_t  rd_d;

	// all arguments of this bundle decode inside one address space
	assign wr_ctrl = reg_wr_i && (reg_addr_i == OFS_CTRL);
	assign wr_gie  = reg_wr_i && (reg_addr_i == OFS_GIE);
	assign wr_ier  = reg_wr_i && (reg_addr_i == OFS_IER);
	assign wr_isr  = reg_wr_i && (reg_addr_i == OFS_ISR);
	assign wr_a    = reg_wr_i && (reg_addr_i == OFS_ARG_A);
	assign wr_b    = reg_wr_i && (reg_addr_i == OFS_ARG_B);
	assign wr_bvld = reg_wr_i && (reg_addr_i == OFS_ARG_BVLD);
	// valid after this edge's consume, ignoring a software set, so stall, start and valid agree
	assign b_vld_nx = b_vld_q && !core_b_rd_i;

	lcr_sync u_hold_sync (
		.clk_sys_i(clk_sys_i),
		.rst_i    (rst_i),
		.d_i      (ext_hold_i),
		.q_o      (hold_s)
	);

	// start: software sets, cleared once the core accepts input
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			start_q <= 1'b0;
		end else if (wr_ctrl && reg_wdata_i[CTRL_START]) begin
			start_q <= 1'b1;
		end else if (core_ready_i) begin
			start_q <= 1'b0;
		end
	end

	// done is clear-on-read; a fresh done in the read cycle survives
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			done_seen_q <= 1'b0;
		end else if (core_done_i) begin
			done_seen_q <= 1'b1;
		end else if (reg_rd_i && (reg_addr_i == OFS_CTRL)) begin
			done_seen_q <= 1'b0;
		end
	end

	// run state: waiting on the valid register holds the core back
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			state_q <= LCR_IDLE;
		end else begin
			case (state_q)
				LCR_IDLE: begin
					if (start_q) begin
						state_q <= b_vld_q ? LCR_RUN : LCR_WAIT;
					end
				end
				LCR_WAIT: begin
					if (b_vld_q) begin
						state_q <= LCR_RUN;
					end
				end
				LCR_RUN: begin
					if (core_done_i) begin
						state_q <= LCR_IDLE;
					end
				end
				default: state_q <= LCR_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			stall_o <= 1'b1;
		end else begin
			stall_o <= (state_q == LCR_WAIT) || !b_vld_nx || hold_s;
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			core_start_o <= 1'b0;
		end else begin
			core_start_o <= start_q && b_vld_nx;
		end
	end

	// argument registers: reset to zero only, no other default
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			a_q <= '0;
		end else if (wr_a) begin
			a_q <= reg_wdata_i[ARG_W-1:0];
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			b_q <= '0;
		end else if (wr_b) begin
			b_q <= reg_wdata_i[ARG_W-1:0];
		end
	end

	// consume beats software set: valid clears whenever the core reads b while valid is set
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			b_vld_q <= 1'b0;
		end else if (core_b_rd_i && b_vld_q) begin
			b_vld_q <= 1'b0;
		end else if (wr_bvld && reg_wdata_i[0]) begin
			b_vld_q <= 1'b1;
		end
	end

	// acknowledge: set on consumption, cleared when read back
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			b_ack_q <= 1'b0;
		end else if (core_b_rd_i && b_vld_q) begin
			b_ack_q <= 1'b1;
		end else if (reg_rd_i && (reg_addr_i == OFS_ARG_BACK)) begin
			b_ack_q <= 1'b0;
		end
	end

	// c sits at its fixed offset, captured from the core
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			c_q <= '0;
		end else if (arg_c_vld_i) begin
			c_q <= arg_c_i;
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			arg_a_o     <= '0;
			arg_b_o     <= '0;
			arg_b_vld_o <= 1'b0;
		end else begin
			arg_a_o     <= a_q;
			arg_b_o     <= b_q;
			arg_b_vld_o <= b_vld_nx;
		end
	end

	// interrupt enables and global enable
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			gie_q <= 1'b0;
			ier_q <= '0;
		end else begin
			if (wr_gie) begin
				gie_q <= reg_wdata_i[0];
			end
			if (wr_ier) begin
				ier_q <= reg_wdata_i[IRQ_W-1:0];
			end
		end
	end

	assign isr_clr = wr_isr ? reg_wdata_i[IRQ_W-1:0] : '0;

	lcr_flag u_isr_done (
		.clk_sys_i(clk_sys_i),
		.rst_i    (rst_i),
		.set_i    (core_done_i),
		.clr_i    (isr_clr[IRQ_DONE]),
		.flag_o   (isr[IRQ_DONE])
	);

	lcr_flag u_isr_ready (
		.clk_sys_i(clk_sys_i),
		.rst_i    (rst_i),
		.set_i    (core_ready_i),
		.clr_i    (isr_clr[IRQ_READY]),
		.flag_o   (isr[IRQ_READY])
	);

	// registered so the level never glitches on the enable write
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= gie_q && |(isr & ier_q);
		end
	end

	// read mux; no memory-style or constant argument is decoded here
	always_comb begin
		rd_d = ZERO;
		hit  = 1'b1;
		case (reg_addr_i)
			OFS_CTRL: begin
				rd_d[CTRL_START] = start_q;
				rd_d[CTRL_DONE]  = done_seen_q;
				rd_d[CTRL_IDLE]  = core_idle_i;
				rd_d[CTRL_READY] = core_ready_i;
			end
			OFS_GIE:      rd_d[0] = gie_q;
			OFS_IER:      rd_d[IRQ_W-1:0] = ier_q;
			OFS_ISR:      rd_d[IRQ_W-1:0] = isr;
			OFS_ARG_A:    rd_d[ARG_W-1:0] = a_q;
			OFS_ARG_B:    rd_d[ARG_W-1:0] = b_q;
			OFS_ARG_BVLD: rd_d[0] = b_vld_q;
			OFS_ARG_BACK: rd_d[0] = b_ack_q;
			OFS_ARG_C:    rd_d[ARG_W-1:0] = c_q;
			default:      hit = 1'b0;
		endcase
	end

	// unmapped addresses read zero and raise the error flag for one cycle
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			reg_rdata_o <= ZERO;
			reg_err_o   <= 1'b0;
		end else begin
			reg_rdata_o <= reg_rd_i ? rd_d : ZERO;
			reg_err_o   <= (reg_rd_i || reg_wr_i) && !hit;
		end
	end
endmodule

/* rtl/lcr_sync.sv */
// lcr_sync: two-stage synchroniser for a level from outside the clock domain
// assumes: destination clock clk_sys_i, asynchronous active-high reset
`timescale 1ns/1ps
module lcr_sync (
	// clock and reset
	input  wire logic clk_sys_i,
	input  wire logic rst_i,
	// level
	input  wire logic d_i,
	output logic      q_o
);
	logic meta_q;
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			meta_q <= 1'b0;
			q_o    <= 1'b0;
		end else begin
			meta_q <= d_i;
			q_o    <= meta_q;
		end
	end
endmodule

/* tb/lcr_core_model.sv */
// lcr_core_model: behavioural kernel that sums arguments a and b into c
// assumes: shares clk_sys_i with the slave, latency given by the bench
`timescale 1ns/1ps
module lcr_core_model (
	// clock and reset
	input  wire logic        clk_sys_i,
	input  wire logic        rst_i,
	// handshake with the slave
	input  wire logic        start_i,
	input  wire logic        stall_i,
	input  wire logic [31:0] a_i,
	input  wire logic [31:0] b_i,
	input  wire logic [3:0]  lat_i,
	output logic             fire_o,
	output logic             idle_o,
	output logic [31:0]      c_o
);
	logic [4:0] cnt_q;
	// three cycles of cooldown let the registered start drop before a rerun
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_q <= 5'h0;
		end else if (cnt_q != 5'h0) begin
			cnt_q <= cnt_q - 5'h1;
		end else if (start_i && !stall_i) begin
			cnt_q <= {1'b0, lat_i} + 5'h4;
		end
	end
	assign fire_o = cnt_q == 5'h4;
	assign idle_o = cnt_q == 5'h0;
	// result is junk outside its strobe, as a real kernel bus would be
	assign c_o = fire_o ? a_i + b_i : ~(a_i + b_i);
endmodule

/* tb/lcr_slave_properties.sv */
// lcr_slave_properties: port checks of the control register slave
// assumes: one clock, bound onto every lcr_slave instance
`timescale 1ns/1ps
module lcr_slave_properties
	import lcr_pkg::*;
#(
	parameter int unsigned ARG_W = 32
) (
	// clock and reset
	input  wire logic               clk_sys_i,
	input  wire logic               rst_i,
	// register port
	input  wire lcr_pkg::lcr_addr_t reg_addr_i,
	input  wire lcr_pkg::lcr_data_t reg_wdata_i,
	input  wire logic               reg_wr_i,
	input  wire logic               reg_rd_i,
	input  wire lcr_pkg::lcr_data_t reg_rdata_o,
	input  wire logic               reg_err_o,
	// kernel side
	input  wire logic               core_start_o,
	input  wire logic               core_b_rd_i,
	input  wire logic [ARG_W-1:0]   arg_a_o,
	input  wire logic [ARG_W-1:0]   arg_b_o,
	input  wire logic               arg_b_vld_o,
	input  wire logic               stall_o,
	input  wire logic               irq_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	sequence s_gie_off;
		reg_wr_i && reg_addr_i == OFS_GIE && !reg_wdata_i[0];
	endsequence
	// a second write right behind reaches arg_b_o only a cycle after the copy is checked
	sequence s_b_write;
		reg_wr_i && reg_addr_i == OFS_ARG_B ##1 !(reg_wr_i && reg_addr_i == OFS_ARG_B);
	endsequence
	chk_rdata_idle: assert property (reg_rdata_o != 32'h0 |-> $past(reg_rd_i))
		else $error("read data outside a read answer");
	chk_err_cause: assert property (reg_err_o |-> $past(reg_wr_i || reg_rd_i))
		else $error("error pulse without access");
	chk_err_window: assert property ((reg_wr_i || reg_rd_i) && reg_addr_i <= CTRL_TOP |=> !reg_err_o)
		else $error("control window refused");
	chk_c_mapped: assert property (reg_rd_i && reg_addr_i == OFS_ARG_C |=> !reg_err_o)
		else $error("offset argument refused");
	chk_vld_clear: assert property (core_b_rd_i |-> ##2 !arg_b_vld_o)
		else $error("valid kept after consume");
	chk_stall_invalid: assert property (!arg_b_vld_o |-> stall_o)
		else $error("no stall on invalid data");
	chk_start_valid: assert property (core_start_o |-> arg_b_vld_o)
		else $error("start without valid data");
	chk_irq_gate: assert property (s_gie_off |=> ##1 !irq_o)
		else $error("interrupt despite global disable");
	chk_rd_arg: assert property (reg_rd_i && reg_addr_i == OFS_ARG_A |=> reg_rdata_o == arg_a_o)
		else $error("argument readback differs");
	chk_b_copy: assert property (s_b_write |=> arg_b_o == $past(reg_wdata_i, 2))
		else $error("argument data not passed on");
endmodule
bind lcr_slave lcr_slave_properties #(.ARG_W(ARG_W)) u_props (
	.clk_sys_i(clk_sys_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
	.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
	.reg_rdata_o(reg_rdata_o), .reg_err_o(reg_err_o), .core_start_o(core_start_o),
	.core_b_rd_i(core_b_rd_i), .arg_a_o(arg_a_o), .arg_b_o(arg_b_o),
	.arg_b_vld_o(arg_b_vld_o), .stall_o(stall_o), .irq_o(irq_o)
);

/* tb/lcr_slave_tb.sv */
// lcr_slave_tb: random and corner tests of the control register slave
// assumes: package, slave, kernel model and bound checker compiled first
`timescale 1ns/1ps
module lcr_slave_tb;
	import lcr_pkg::*;
	logic clk_sys_i = 1'b0;
	logic rst_i = 1'b1;
	lcr_addr_t addr = 12'h0;
	lcr_data_t wdata = 32'h0;
	lcr_data_t rdata, got, a, b, c;
	logic wr = 1'b0, rd = 1'b0, hold = 1'b0, err, gerr, girq, start, fire, idle, bv, stall, irq;
	logic [31:0] ao, bo;
	logic [3:0] lat = 4'h0;
	int bad_count = 0, n_compared = 0, cyc = 0;
	lcr_addr_t rst_tab[6] = '{OFS_ARG_A, OFS_ARG_B, OFS_ARG_BVLD, OFS_GIE, OFS_IER, OFS_ISR};
	always #2 clk_sys_i = ~clk_sys_i;
	lcr_slave #(.ARG_W(32)) uut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .reg_addr_i(addr),
		.reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .reg_err_o(err),
		.core_start_o(start), .core_done_i(fire), .core_ready_i(fire), .core_idle_i(idle),
		.core_b_rd_i(fire), .arg_a_o(ao), .arg_b_o(bo), .arg_b_vld_o(bv), .arg_c_i(c),
		.arg_c_vld_i(fire), .ext_hold_i(hold), .stall_o(stall), .irq_o(irq));
	lcr_core_model u_core (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .start_i(start), .stall_i(stall),
		.a_i(ao), .b_i(bo), .lat_i(lat), .fire_o(fire), .idle_o(idle), .c_o(c));
	function automatic lcr_data_t exp_irq(input int ier);
		return {31'h0, ier != 0};
	endfunction
	task automatic chk(input lcr_data_t g, input lcr_data_t e);
		n_compared++;
		if (g !== e) begin
			bad_count++;
			$display("BAD %0t got %h want %h", $time, g, e);
		end
	endtask
	task automatic acc(input logic w, input lcr_addr_t ad, input lcr_data_t d);
		addr <= ad;
		wdata <= d;
		wr <= w;
		rd <= !w;
		@(posedge clk_sys_i);
		wr <= 1'b0;
		rd <= 1'b0;
		#1;
		got = rdata;
		gerr = err;
		girq = irq;
		@(posedge clk_sys_i);
	endtask
	task automatic final_report;
		$display("compared %0d bad %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc == 3000) begin
			bad_count++;
			final_report();
		end
	end
	initial begin
		void'($urandom(32'h4825dea9));
		repeat (6) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		@(posedge clk_sys_i);
		acc(1, OFS_ARG_C, 32'hffff_ffff);
		foreach (rst_tab[i]) begin
			acc(0, rst_tab[i], 32'h0);
			chk(got, 32'h0);
		end
		acc(0, OFS_ARG_C, 32'h0);
		chk(got, 32'h0);
		acc(0, 12'h100, 32'h0);
		chk({31'h0, gerr}, 32'h1);
		for (int i = 0; i < 4; i++) begin
			a = $urandom();
			b = $urandom();
			lat <= 4'($urandom_range(15));
			hold <= i[0];
			acc(1, OFS_ARG_A, a);
			acc(1, OFS_ARG_B, b);
			acc(1, OFS_IER, 32'(i));
			acc(1, OFS_GIE, 32'h1);
			acc(1, OFS_CTRL, 32'h1);
			hold <= 1'b0;
			acc(1, OFS_ARG_BVLD, 32'h1);
			for (int k = 0; k < 40 && !fire; k++) @(posedge clk_sys_i) #1;
			chk({31'h0, fire}, 32'h1);
			repeat (3) @(posedge clk_sys_i);
			acc(0, OFS_ISR, 32'h0);
			chk(got, 32'h3);
			chk({31'h0, girq}, exp_irq(i));
			acc(0, OFS_ARG_BVLD, 32'h0);
			chk(got, 32'h0);
			acc(0, OFS_ARG_BACK, 32'h0);
			chk(got, 32'h1);
			acc(0, OFS_ARG_C, 32'h0);
			chk(got, a + b);
			acc(1, OFS_ISR, 32'h3);
			acc(0, OFS_ISR, 32'h0);
			chk({got[30:0], girq}, 32'h0);
			acc(1, OFS_GIE, 32'h0);
		end
		final_report();
	end
endmodule
